/* tpmt_pkg.sv */
// tpmt_pkg: constants, types and helpers for the telemetry peak/min tracker.
// assumes one device clock; adc results arrive as one-cycle strobes from the sequencer.
package tpmt_pkg;
   localparam int TPMT_NCH = 4;

   // ----------------------------------------------------------------
   // read command codes and the all-pages page number
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_VIN = 8'h88;
   localparam logic [7:0] CMD_VOUT = 8'h8B;
   localparam logic [7:0] CMD_IOUT = 8'h8C;
   localparam logic [7:0] CMD_TEMP1 = 8'h8D;
   localparam logic [7:0] CMD_TEMP2 = 8'h8E;
   localparam logic [7:0] CMD_POUT = 8'h96;
   localparam logic [7:0] CMD_FINE_IOUT = 8'hBB;
   localparam logic [7:0] CMD_SENSE_V = 8'hFA;
   localparam logic [7:0] CMD_VIN_MAX = 8'hDE;
   localparam logic [7:0] CMD_VOUT_MAX = 8'hDD;
   localparam logic [7:0] CMD_IOUT_MAX = 8'hD7;
   localparam logic [7:0] CMD_TEMP_MAX = 8'hDF;
   localparam logic [7:0] CMD_VIN_LOW = 8'hFC;
   localparam logic [7:0] CMD_VOUT_LOW = 8'hFB;
   localparam logic [7:0] CMD_IOUT_LOW = 8'hD8;
   localparam logic [7:0] CMD_TEMP_LOW = 8'hFD;
   localparam logic [7:0] PAGE_ALL = 8'hFF;

   // ----------------------------------------------------------------
   // reset values and limits
   // ----------------------------------------------------------------
   localparam logic [15:0] READING_RST = 16'h0000;
   localparam logic [15:0] VIN_MAX_RST = 16'h7C00;
   localparam logic [15:0] VIN_LOW_RST = 16'h7BFF;
   localparam logic [15:0] VOUT_MAX_RST = 16'hF800;
   localparam logic [15:0] VOUT_LOW_RST = 16'hFFFF;
   localparam logic [15:0] IOUT_MAX_RST = 16'h7C00;
   localparam logic [15:0] IOUT_LOW_RST = 16'h7BFF;
   localparam logic [15:0] TEMP_MAX_RST = 16'h7C00;
   localparam logic [15:0] TEMP_LOW_RST = 16'h7BFF;
   localparam logic [15:0] FINE_POS_SAT = 16'h7FFF;
   localparam logic [15:0] FINE_NEG_SAT = 16'h8000;
   localparam logic [15:0] SENSE_SAT = 16'hFFFF;

   // ----------------------------------------------------------------
   // linear-11 field layout
   // ----------------------------------------------------------------
   localparam int L11_EXP_MSB = 15;
   localparam int L11_EXP_LSB = 11;
   localparam int L11_MAN_MSB = 10;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [5:0] {
      TPMT_K_VIN = 6'b00_0001,
      TPMT_K_VOUT = 6'b00_0010,
      TPMT_K_IOUT = 6'b00_0100,
      TPMT_K_TEXT = 6'b00_1000,
      TPMT_K_TINT = 6'b01_0000,
      TPMT_K_POUT = 6'b10_0000
   } tpmt_kind_type;

   typedef struct packed {
      logic valid;
      tpmt_kind_type kind;
      logic [1:0] ch;
      logic [15:0] word;
      logic signed [23:0] fine_cnt;
      logic signed [16:0] sense_raw;
   } tpmt_adc_type;

   typedef struct packed {
      logic req;
      logic [7:0] cmd;
      logic [7:0] page;
   } tpmt_rd_type;

   typedef struct packed {
      logic [15:0] vout, iout, text, pout, fine, sense;
      logic [15:0] vout_max, vout_low, iout_max, iout_low, temp_max, temp_low;
   } tpmt_chan_type;

   typedef struct packed {
      tpmt_chan_type [TPMT_NCH-1:0] ch;
      logic [15:0] vin, tint, vin_max, vin_low;
      logic [TPMT_NCH-1:0] on_prev;
      logic [15:0] rd_data;
      logic ack;
      logic err;
   } tpmt_state_type;

   // decoded linear-11 value, scaled by 2^16 so every exponent is a left shift
   function automatic logic signed [47:0] tpmt_l11_val(input logic [15:0] w);
      logic [4:0] sh;
      logic signed [47:0] m;
      sh = {~w[L11_EXP_MSB], w[L11_EXP_MSB-1:L11_EXP_LSB]};
      m = 48'(signed'(w[L11_MAN_MSB:0]));
      return m <<< sh;
   endfunction
endpackage

/* tpmt_tracker.sv */
// tpmt_tracker: latest readings, peak and low trackers, and command readback.
// assumes the adc sequencer, power control and command decoder share MCLK.
module tpmt_tracker (
   // clock and reset
   input wire logic MCLK,
   input wire logic RESET_N,
   // adc results
   input wire tpmt_pkg::tpmt_adc_type ADC_RESULT,
   // channel status
   input wire logic [tpmt_pkg::TPMT_NCH-1:0] CHANNEL_ON,
   input wire logic [tpmt_pkg::TPMT_NCH-1:0] MARGIN_LOW_IGNORE,
   input wire logic [tpmt_pkg::TPMT_NCH-1:0] EXTERNAL_TEMP_SENSE_NETWORK_OK,
   // clear faults command
   input wire logic CLEAR_FAULTS,
   input wire logic [7:0] CLEAR_PAGE,
   // readback
   input wire tpmt_pkg::tpmt_rd_type READ_REQ,
   output logic [15:0] READ_DATA,
   output logic READ_ACK,
   output logic READ_ERR
);
   import tpmt_pkg::*;

   // ----------------------------------------------------------------
   // reset image
   // ----------------------------------------------------------------
   localparam tpmt_chan_type CHAN_RST = '{
      vout: READING_RST,
      iout: READING_RST,
      text: READING_RST,
      pout: READING_RST,
      fine: READING_RST,
      sense: READING_RST,
      vout_max: VOUT_MAX_RST,
      vout_low: VOUT_LOW_RST,
      iout_max: IOUT_MAX_RST,
      iout_low: IOUT_LOW_RST,
      temp_max: TEMP_MAX_RST,
      temp_low: TEMP_LOW_RST
   };

   localparam tpmt_state_type STATE_RST = '{
      ch: {TPMT_NCH{CHAN_RST}},
      vin: READING_RST,
      tint: READING_RST,
      vin_max: VIN_MAX_RST,
      vin_low: VIN_LOW_RST,
      on_prev: '0,
      rd_data: READING_RST,
      ack: 1'b0,
      err: 1'b0
   };

   tpmt_state_type state_reg;
   tpmt_state_type state_next;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic l11_gt(input logic [15:0] a, input logic [15:0] b);
      return tpmt_l11_val(a) > tpmt_l11_val(b);
   endfunction

   function automatic logic l11_lt(input logic [15:0] a, input logic [15:0] b);
      return tpmt_l11_val(a) < tpmt_l11_val(b);
   endfunction

   // fine current count of 2.5 mA steps, clipped to the 16-bit range
   function automatic logic [15:0] fine_sat(input logic signed [23:0] cnt);
      logic [15:0] r;
      if (cnt > 24'sh00_7FFF) begin
         r = FINE_POS_SAT;
      end else if (cnt < -24'sh00_8000) begin
         r = FINE_NEG_SAT;
      end else begin
         r = cnt[15:0];
      end
      return r;
   endfunction

   // magnitude of the raw sense differential, clipped to 16 bits
   function automatic logic [15:0] sense_mag(input logic signed [16:0] raw);
      logic [16:0] m;
      m = raw[16] ? 17'(-raw) : 17'(raw);
      return m[16] ? SENSE_SAT : m[15:0];
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [1:0] c;
      logic any_on;
      logic rise;
      logic clr;
      logic [1:0] p;
      logic page_ok;
      c = ADC_RESULT.ch;
      any_on = 1'b0;
      rise = 1'b0;
      clr = 1'b0;
      p = READ_REQ.page[1:0];
      page_ok = READ_REQ.page < 8'(TPMT_NCH);
      state_next = state_reg;
      state_next.ack = 1'b0;
      state_next.err = 1'b0;

      // adc results update readings and trackers
      if (ADC_RESULT.valid) begin
         unique case (ADC_RESULT.kind)
            TPMT_K_VIN: begin
               state_next.vin = ADC_RESULT.word;
               if (l11_gt(ADC_RESULT.word, state_reg.vin_max)) begin
                  state_next.vin_max = ADC_RESULT.word;
               end
               if (l11_lt(ADC_RESULT.word, state_reg.vin_low)) begin
                  state_next.vin_low = ADC_RESULT.word;
               end
            end
            TPMT_K_VOUT: begin
               state_next.ch[c].vout = ADC_RESULT.word;
               // linear-16 has a fixed exponent: the unsigned mantissa is the value
               // the peak reset code stands for zero, so any reading replaces it
               if (state_reg.ch[c].vout_max == VOUT_MAX_RST ||
                   ADC_RESULT.word > state_reg.ch[c].vout_max) begin
                  state_next.ch[c].vout_max = ADC_RESULT.word;
               end
               if (!MARGIN_LOW_IGNORE[c] &&
                   ADC_RESULT.word < state_reg.ch[c].vout_low) begin
                  state_next.ch[c].vout_low = ADC_RESULT.word;
               end
            end
            TPMT_K_IOUT: begin
               state_next.ch[c].iout = ADC_RESULT.word;
               state_next.ch[c].fine = fine_sat(ADC_RESULT.fine_cnt);
               // uncorrected conversion value of the same sample
               state_next.ch[c].sense = sense_mag(ADC_RESULT.sense_raw);
               if (l11_gt(ADC_RESULT.word, state_reg.ch[c].iout_max)) begin
                  state_next.ch[c].iout_max = ADC_RESULT.word;
               end
               if (l11_lt(ADC_RESULT.word, state_reg.ch[c].iout_low)) begin
                  state_next.ch[c].iout_low = ADC_RESULT.word;
               end
            end
            TPMT_K_TEXT: begin
               state_next.ch[c].text = ADC_RESULT.word;
               // a failed sense network's own samples are not tracked
               if (EXTERNAL_TEMP_SENSE_NETWORK_OK[c]) begin
                  if (l11_gt(ADC_RESULT.word, state_reg.ch[c].temp_max)) begin
                     state_next.ch[c].temp_max = ADC_RESULT.word;
                  end
                  if (l11_lt(ADC_RESULT.word, state_reg.ch[c].temp_low)) begin
                     state_next.ch[c].temp_low = ADC_RESULT.word;
                  end
               end
            end
            TPMT_K_TINT: begin
               state_next.tint = ADC_RESULT.word;
               // internal reading touches a channel only when standing in for it
               for (int i = 0; i < TPMT_NCH; i++) begin
                  if (!EXTERNAL_TEMP_SENSE_NETWORK_OK[i]) begin
                     if (l11_gt(ADC_RESULT.word, state_reg.ch[i].temp_max)) begin
                        state_next.ch[i].temp_max = ADC_RESULT.word;
                     end
                     if (l11_lt(ADC_RESULT.word, state_reg.ch[i].temp_low)) begin
                        state_next.ch[i].temp_low = ADC_RESULT.word;
                     end
                  end
               end
            end
            TPMT_K_POUT: begin
               state_next.ch[c].pout = ADC_RESULT.word;
            end
            default: begin
            end
         endcase
      end

      // turn-on and clear-faults restart the trackers; they win over a sample
      for (int i = 0; i < TPMT_NCH; i++) begin
         rise = CHANNEL_ON[i] & ~state_reg.on_prev[i];
         clr = CLEAR_FAULTS & ((CLEAR_PAGE == 8'(i)) | (CLEAR_PAGE == PAGE_ALL));
         any_on = any_on | rise;
         if (rise || clr) begin
            state_next.ch[i].vout_max = VOUT_MAX_RST;
            state_next.ch[i].vout_low = VOUT_LOW_RST;
            state_next.ch[i].iout_max = IOUT_MAX_RST;
            state_next.ch[i].iout_low = IOUT_LOW_RST;
            state_next.ch[i].temp_max = TEMP_MAX_RST;
            state_next.ch[i].temp_low = TEMP_LOW_RST;
         end
      end
      state_next.on_prev = CHANNEL_ON;

      // input voltage trackers are shared: any page, any channel
      if (CLEAR_FAULTS || any_on) begin
         state_next.vin_max = VIN_MAX_RST;
         state_next.vin_low = VIN_LOW_RST;
      end

      // ----------------------------------------------------------------
      // readback
      // ----------------------------------------------------------------
      if (READ_REQ.req) begin
         state_next.ack = 1'b1;
         state_next.rd_data = READING_RST;
         unique case (READ_REQ.cmd)
            CMD_VIN: begin
               state_next.rd_data = state_reg.vin;
            end
            CMD_TEMP2: begin
               state_next.rd_data = state_reg.tint;
            end
            CMD_VIN_MAX: begin
               state_next.rd_data = state_reg.vin_max;
            end
            CMD_VIN_LOW: begin
               state_next.rd_data = state_reg.vin_low;
            end
            CMD_VOUT, CMD_IOUT, CMD_TEMP1, CMD_POUT, CMD_FINE_IOUT, CMD_SENSE_V,
            CMD_VOUT_MAX, CMD_IOUT_MAX, CMD_TEMP_MAX,
            CMD_VOUT_LOW, CMD_IOUT_LOW, CMD_TEMP_LOW: begin
               if (!page_ok) begin
                  state_next.err = 1'b1;
               end else begin
                  unique case (READ_REQ.cmd)
                     CMD_VOUT: state_next.rd_data = state_reg.ch[p].vout;
                     CMD_IOUT: state_next.rd_data = state_reg.ch[p].iout;
                     CMD_TEMP1: begin
                        state_next.rd_data = EXTERNAL_TEMP_SENSE_NETWORK_OK[p] ?
                           state_reg.ch[p].text : state_reg.tint;
                     end
                     CMD_POUT: state_next.rd_data = state_reg.ch[p].pout;
                     CMD_FINE_IOUT: state_next.rd_data = state_reg.ch[p].fine;
                     CMD_SENSE_V: state_next.rd_data = state_reg.ch[p].sense;
                     CMD_VOUT_MAX: state_next.rd_data = state_reg.ch[p].vout_max;
                     CMD_IOUT_MAX: state_next.rd_data = state_reg.ch[p].iout_max;
                     CMD_TEMP_MAX: state_next.rd_data = state_reg.ch[p].temp_max;
                     CMD_VOUT_LOW: state_next.rd_data = state_reg.ch[p].vout_low;
                     CMD_IOUT_LOW: state_next.rd_data = state_reg.ch[p].iout_low;
                     default: state_next.rd_data = state_reg.ch[p].temp_low;
                  endcase
               end
            end
            default: begin
               state_next.err = 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_reg <= STATE_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   assign READ_DATA = state_reg.rd_data;
   assign READ_ACK = state_reg.ack;
   assign READ_ERR = state_reg.err;
endmodule

/* tpmt_host.sv */
// tpmt_host: bus host model that issues one readback request at a time.
// assumes calls start just after a rising MCLK edge.
module tpmt_host (
   // clock
   input wire logic MCLK,
   // request
   output tpmt_pkg::tpmt_rd_type READ_REQ,
   // answer
   input wire logic [15:0] READ_DATA,
   input wire logic READ_ACK,
   input wire logic READ_ERR
);
   import tpmt_pkg::*;
   initial READ_REQ = '0;
   // one-cycle request; released fields are scrambled, not left at the old value
   task automatic read(input logic [7:0] cmd, input logic [7:0] page,
                       output logic [15:0] data, output logic err, output logic ok);
      READ_REQ = '{req: 1'b1, cmd: cmd, page: page};
      @(posedge MCLK);
      // the answer stands only in the cycle after the taking edge
      #1 READ_REQ = '{req: 1'b0, cmd: ~cmd, page: ~page};
      ok = READ_ACK;
      data = READ_DATA;
      err = READ_ERR;
      // let an edge pass so a following call does not drive the request twice at once
      @(posedge MCLK);
      #1;
   endtask
endmodule

/* tpmt_tracker_sva.sv */
// tpmt_tracker_sva: readback and tracker checks on the tracker's ports.
// assumes requests and adc strobes are sampled on rising MCLK.
module tpmt_sva (
   // clock and reset
   input wire logic MCLK,
   input wire logic RESET_N,
   // stimulus
   input wire tpmt_pkg::tpmt_adc_type ADC_RESULT,
   input wire logic CLEAR_FAULTS,
   input wire tpmt_pkg::tpmt_rd_type READ_REQ,
   // readback
   input wire logic [15:0] READ_DATA,
   input wire logic READ_ACK,
   input wire logic READ_ERR
);
   import tpmt_pkg::*;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESET_N);
   sequence s_rd(logic [7:0] c);
      READ_REQ.req && READ_REQ.cmd == c;
   endsequence
   sequence s_iout0;
      ADC_RESULT.valid && ADC_RESULT.kind == TPMT_K_IOUT && ADC_RESULT.ch == 2'd0;
   endsequence
   chk_ack_follows: assert property (READ_REQ.req |=> READ_ACK)
      else $error("no answer one cycle after a request");
   chk_ack_caused: assert property (READ_ACK |-> $past(READ_REQ.req))
      else $error("answer without a request");
   chk_data_holds: assert property (!READ_ACK |-> $stable(READ_DATA))
      else $error("read data changed without an answer");
   chk_bad_page: assert property (s_rd(CMD_FINE_IOUT) ##0 READ_REQ.page >= 8'h04
      |=> READ_ERR && READ_DATA == 16'h0000) else $error("bad page not refused");
   chk_tint_unpaged: assert property (s_rd(CMD_TEMP2) |=> !READ_ERR)
      else $error("internal temperature read refused");
   chk_vin_max_clr: assert property (CLEAR_FAULTS ##1 s_rd(CMD_VIN_MAX)
      |=> READ_DATA == VIN_MAX_RST) else $error("input peak not reset by clear");
   chk_vin_low_clr: assert property (CLEAR_FAULTS ##1 s_rd(CMD_VIN_LOW)
      |=> READ_DATA == VIN_LOW_RST) else $error("input low not reset by clear");
   chk_fine_sat: assert property (s_iout0 ##0 ADC_RESULT.fine_cnt > 24'sh00_7FFF
      ##1 s_rd(CMD_FINE_IOUT) ##0 READ_REQ.page == 8'h00 |=> READ_DATA == FINE_POS_SAT)
      else $error("fine current not saturated");
   chk_sense_abs: assert property (s_iout0 ##0 ADC_RESULT.sense_raw[16]
      ##0 ADC_RESULT.sense_raw != 17'h1_0000 ##1 s_rd(CMD_SENSE_V) ##0 READ_REQ.page == 8'h00
      |=> READ_DATA == 16'(-$past(ADC_RESULT.sense_raw, 2)))
      else $error("sense voltage not the raw magnitude");
endmodule
bind tpmt_tracker tpmt_sva u_sva (.MCLK(MCLK), .RESET_N(RESET_N), .ADC_RESULT(ADC_RESULT),
   .CLEAR_FAULTS(CLEAR_FAULTS), .READ_REQ(READ_REQ), .READ_DATA(READ_DATA),
   .READ_ACK(READ_ACK), .READ_ERR(READ_ERR));

/* tpmt_tracker_bench.sv */
// tpmt_tracker_bench: directed readback tests of the telemetry tracker.
// assumes tpmt_host issues reads; inputs change 1 ns after rising MCLK.
module tpmt_tracker_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import tpmt_pkg::*;
   `define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
      $display("mismatch at %0t got %h exp %h", $time, g, e); end end
   logic MCLK = 1'b0;
   logic RESET_N = 1'b0;
   tpmt_adc_type adc = '0;
   logic [3:0] on = 4'h0;
   logic [3:0] mli = 4'h0;
   logic [3:0] sok = 4'hF;
   logic clr_p = 1'b0;
   logic [7:0] clr_pg = 8'h00;
   tpmt_rd_type rq;
   logic [15:0] rdat;
   logic ack, rerr;
   int err_count = 0;
   int tests_run = 0;
   logic [7:0] rc[8] = '{CMD_VIN_MAX, CMD_VIN_LOW, CMD_VOUT_MAX, CMD_VOUT_LOW,
                         CMD_IOUT_MAX, CMD_IOUT_LOW, CMD_TEMP_MAX, CMD_TEMP_LOW};
   logic [15:0] rv[8] = '{VIN_MAX_RST, VIN_LOW_RST, VOUT_MAX_RST, VOUT_LOW_RST,
                          IOUT_MAX_RST, IOUT_LOW_RST, TEMP_MAX_RST, TEMP_LOW_RST};
   always #5 MCLK = ~MCLK;
   tpmt_tracker DUT (.MCLK(MCLK), .RESET_N(RESET_N), .ADC_RESULT(adc), .CHANNEL_ON(on),
      .MARGIN_LOW_IGNORE(mli), .EXTERNAL_TEMP_SENSE_NETWORK_OK(sok), .CLEAR_FAULTS(clr_p),
      .CLEAR_PAGE(clr_pg), .READ_REQ(rq), .READ_DATA(rdat), .READ_ACK(ack), .READ_ERR(rerr));
   tpmt_host host (.MCLK(MCLK), .READ_REQ(rq), .READ_DATA(rdat), .READ_ACK(ack),
      .READ_ERR(rerr));
   // -----
   // tasks
   // -----
   task automatic conclude();
      $display("counts: %0d compares, %0d mismatches", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic note(string s);
      $display("test %s done, %0d mismatches so far", s, err_count);
   endtask
   task automatic rd(input logic [7:0] c, input logic [7:0] p, input logic [15:0] e,
                     input logic ee = 1'b0);
      logic [15:0] d;
      logic er, ok;
      host.read(c, p, d, er, ok);
      if (!ok) begin
         err_count++;
         conclude();
      end else `CHK({er, d}, {ee, e})
   endtask
   task automatic sample(tpmt_kind_type k, logic [1:0] ch, logic [15:0] w,
                         logic [23:0] f = '0, logic [16:0] s = '0);
      @(posedge MCLK);
      #1 adc = '{1'b1, k, ch, w, f, s};
      @(posedge MCLK);
      #1 adc = '{1'b0, k, ch, ~w, ~f, ~s};
   endtask
   task automatic clear(logic [7:0] p);
      clr_p = 1'b1;
      clr_pg = p;
      @(posedge MCLK);
      #1 clr_p = 1'b0;
      clr_pg = ~p;
   endtask
   task automatic chk_rst(logic [7:0] p);
      for (int i = 0; i < 8; i++) rd(rc[i], p, rv[i]);
   endtask
   // -----
   // main sequence
   // -----
   initial begin
      repeat (4) @(posedge MCLK);
      #1 RESET_N = 1'b1;
      chk_rst(8'h00);
      note("reset values");
      sample(TPMT_K_VIN, 0, 16'h0803);
      sample(TPMT_K_VIN, 0, 16'hF008);
      sample(TPMT_K_VIN, 0, 16'h0005);
      rd(CMD_VIN_MAX, 8'h00, 16'h0803);
      rd(CMD_VIN_LOW, 8'h00, 16'hF008);
      rd(CMD_VIN, 8'h00, 16'h0005);
      note("input tracking");
      sample(TPMT_K_VOUT, 0, 16'h2000);
      sample(TPMT_K_VOUT, 2, 16'h3000);
      mli = 4'b0001;
      sample(TPMT_K_VOUT, 0, 16'h1000);
      rd(CMD_VOUT_LOW, 8'h00, 16'h2000);
      mli = 4'b0000;
      sample(TPMT_K_VOUT, 0, 16'h1800);
      rd(CMD_VOUT_LOW, 8'h00, 16'h1800);
      rd(CMD_VOUT, 8'h00, 16'h1800);
      rd(CMD_VOUT_MAX, 8'h00, 16'h2000);
      note("output voltage and margin");
      sample(TPMT_K_IOUT, 0, 16'h0803, 24'h00_9C40, 17'h1_0000);
      rd(CMD_FINE_IOUT, 8'h00, 16'h7FFF);
      rd(CMD_SENSE_V, 8'h00, 16'hFFFF);
      sample(TPMT_K_IOUT, 0, 16'hF008, 24'hFF_FFFE, 17'h1_FE06);
      rd(CMD_SENSE_V, 8'h00, 16'h01FA);
      rd(CMD_FINE_IOUT, 8'h00, 16'hFFFE);
      sample(TPMT_K_IOUT, 0, 16'h0005, 24'hFF_63C0, 17'h0_01FA);
      rd(CMD_FINE_IOUT, 8'h00, 16'h8000);
      rd(CMD_IOUT_MAX, 8'h00, 16'h0803);
      rd(CMD_IOUT_LOW, 8'h00, 16'hF008);
      rd(CMD_IOUT, 8'h00, 16'h0005);
      note("current");
      sok = 4'b0111;
      sample(TPMT_K_TEXT, 0, 16'h0019);
      sample(TPMT_K_TINT, 0, 16'h001E);
      rd(CMD_TEMP1, 8'h00, 16'h0019);
      rd(CMD_TEMP2, 8'h05, 16'h001E);
      rd(CMD_TEMP1, 8'h03, 16'h001E);
      rd(CMD_TEMP_MAX, 8'h00, 16'h0019);
      rd(CMD_TEMP_LOW, 8'h03, 16'h001E);
      sample(TPMT_K_POUT, 1, 16'h0123);
      rd(CMD_POUT, 8'h01, 16'h0123);
      note("temperature and power");
      clear(8'h02);
      chk_rst(8'h02);
      rd(CMD_VOUT_MAX, 8'h00, 16'h2000);
      sample(TPMT_K_VIN, 0, 16'h0005);
      sample(TPMT_K_IOUT, 1, 16'h0803);
      @(posedge MCLK);
      #1 on = 4'b0010;
      @(posedge MCLK);
      #1 chk_rst(8'h01);
      rd(CMD_IOUT_MAX, 8'h00, 16'h0803);
      sample(TPMT_K_VIN, 0, 16'h0005);
      clear(8'hFF);
      rd(CMD_VIN_LOW, 8'h00, VIN_LOW_RST);
      note("clear and turn-on");
      rd(CMD_FINE_IOUT, 8'h04, 16'h0000, 1'b1);
      rd(8'h00, 8'h00, 16'h0000, 1'b1);
      note("refused reads");
      conclude();
   end
endmodule
